//--- hw/twi_regs.vh
// Register map, field positions and timing counts of the two-wire engine.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef TWI_REGS_VH
`define TWI_REGS_VH

// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define A_CTL1     3'h0
`define A_BUF      3'h1
`define A_CTL2     3'h2
`define A_OWN      3'h3
`define A_RATE     3'h4
`define A_IDLE     3'h5

// ----------------------------------------
// Field values and positions
// ----------------------------------------
`define C2_START   4'hF
`define C2_STOP    4'hD
`define SBIM_I2C   2'h2
`define SBIM_RST   2'h0
`define SWR_FIRST  2'h2
`define SWR_SECOND 2'h1
`define PRESCALER_ENABLE_BIT   6
`define RUN_BIT    0
`define BC_FULL    3'h0
`define WORD_BITS  4'h8
`define GCALL_ADDR 8'h00

// ----------------------------------------
// Timing: half bus clock is HALF_BASE << divider select
// ----------------------------------------
`define HALF_BASE  16'h0010
`define ZERO16     16'h0000
`define ONE16      16'h0001

`endif

//--- hw/two_wire_bus_transfer_engine.v
// Two-wire bus transfer engine: master/slave, transmitter/receiver.
// Assumes open-drain pins resolved outside; register port on CLK.
// Behaviour
// - Addressing format: direction from eighth bit, address match
// - Free format: all data, no address, direction kept
// - Run-select bit decides running in deep idle
// - Writing 1111 while bus free generates start
// - Master clocks nine pulses; address then acknowledge
// - Ninth falling edge: interrupt, pending clear, stretch
// - Master direction flips only on slave acknowledge
// - Slave acknowledges general call or own address
// - Slave: interrupt, pending clear, stretch clock
// - Buffer write sets pending, next word clocks out
// - Buffer read sets pending; receive, acknowledge low
// - Acknowledge mode off: last word no acknowledge clock
// - One-bit count read clocks high not-acknowledge
// - Stop after not-acknowledge raises stop interrupt
// - Slave releases clock low-time after pending set
// - Stop detected, busy falls, stop interrupt raised
// - Lost arbitration but addressed: clear pending, stretch
// - Lost arbitration otherwise: interrupt, pending unchanged
// - Data line sampled on each rising clock
// - Mismatch on rising clock: arbitration lost, demote
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "twi_regs.vh"
`default_nettype none

module two_wire_bus_transfer_engine (
  input  wire       CLK,              // System clock
  input  wire       SYS_RST,          // Synchronous reset
  input  wire [2:0] ADDR,             // Register address
  input  wire [7:0] WDATA,            // Write data
  input  wire       WR,               // Write strobe
  input  wire       RD,               // Read strobe
  output reg  [7:0] RDATA,            // Read data, cycle after RD
  input  wire       DEEP_IDLE_STATE,  // Core is in deep idle
  input  wire       BUS_CLOCK_LINE_I, // Clock line level
  output reg        BUS_CLOCK_LINE_O, // Clock line drive value
  output reg        BUS_CLOCK_LINE_OE,// Clock line pulled low
  input  wire       BUS_DATA_LINE_I,  // Data line level
  output reg        BUS_DATA_LINE_O,  // Data line drive value
  output reg        BUS_DATA_LINE_OE, // Data line pulled low
  output reg        WORD_DONE_IRQ,    // Word complete pulse
  output reg        STOP_SEEN_IRQ     // Stop seen pulse
);

  // ----------------------------------------
  // Master sequencer states
  // ----------------------------------------
  localparam M_IDLE  = 3'h0;
  localparam M_START = 3'h1;
  localparam M_LOW   = 3'h2;
  localparam M_HIGH  = 3'h3;
  localparam M_STOP  = 3'h4;
  localparam M_REL   = 3'h5;
  localparam M_END   = 3'h6;

  // Bit count zero selects a full word
  function [3:0] word_len;
    input [2:0] bc;
    begin
      word_len = (bc == `BC_FULL) ? `WORD_BITS : {1'b0, bc};
    end
  endfunction

  // Half period of the bus clock in system cycles
  function [15:0] half_cnt;
    input [2:0] sel;
    begin
      half_cnt = `HALF_BASE << sel;
    end
  endfunction

  reg        scl_m_r;
  reg        scl_s_r;
  reg        scl_d_r;
  reg        sda_m_r;
  reg        sda_s_r;
  reg        sda_d_r;
  reg  [2:0] bc_r;
  reg        ack_r;
  reg  [2:0] sck_r;
  reg  [7:0] shreg_r;
  reg        mst_r;
  reg        trx_r;
  reg        bb_r;
  reg        pin_r;
  reg        al_r;
  reg        aas_r;
  reg        gcall_seen_r;
  reg        lrb_r;
  reg  [1:0] sbim_r;
  reg        swr_armed_r;
  reg        swr_go_r;
  reg  [6:0] sa_r;
  reg        als_r;
  reg        prescaler_enable_r;
  reg        run_sel_r;
  reg        first_r;
  reg        session_r;
  reg  [3:0] bitcnt_r;
  reg        stop_req_r;
  reg        stretch_r;
  reg  [2:0] state_r;
  reg [15:0] hcnt_r;
  reg [15:0] rcnt_r;

  // ----------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------
  // Three flops per line; edge logic reads only the second and later
  always @(posedge CLK) begin
    if (SYS_RST) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= BUS_CLOCK_LINE_I;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= BUS_DATA_LINE_I;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  wire scl_rise  = scl_s_r & ~scl_d_r;
  wire scl_fall  = ~scl_s_r & scl_d_r;
  wire start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ----------------------------------------
  // Word shape and drive decisions
  // ----------------------------------------
  wire        addr_word = first_r & ~als_r;
  wire [3:0]  nbits     = addr_word ? `WORD_BITS : word_len(bc_r);
  wire        ack_clk   = addr_word | ack_r;
  wire [3:0]  total     = nbits + {3'h0, ack_clk};
  wire        in_data   = bitcnt_r < nbits;
  wire        gcall     = shreg_r == `GCALL_ADDR;
  wire        hit       = addr_word & ~mst_r & (gcall | (shreg_r[7:1] == sa_r));
  wire        engaged   = mst_r | session_r | first_r | (als_r & bb_r);
  wire        mode_on   = sbim_r == `SBIM_I2C;
  wire        run       = prescaler_enable_r & (~DEEP_IDLE_STATE | run_sel_r) & mode_on;
  wire [15:0] half      = half_cnt(sck_r);
  wire        ack_low   = addr_word ? hit : (ack_r & engaged);
  wire        want_low  = in_data ? (trx_r & engaged & ~shreg_r[7])
                                  : (bitcnt_r == nbits) & ack_clk & ~trx_r & ack_low;

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  wire dbr_acc  = (WR | RD) & (ADDR == `A_BUF);
  wire c2_wr    = WR & (ADDR == `A_CTL2);
  wire c2_start = c2_wr & ~bb_r & (WDATA[7:4] == `C2_START) & mode_on;
  wire c2_stop  = c2_wr & bb_r & (WDATA[7:4] == `C2_STOP);
  wire clr      = SYS_RST | swr_go_r;

  // Mode field and soft reset survive the soft reset itself
  always @(posedge CLK) begin
    if (SYS_RST) begin
      sbim_r      <= `SBIM_RST;
      swr_armed_r <= 1'b0;
      swr_go_r    <= 1'b0;
    end else begin
      swr_go_r <= 1'b0;
      if (c2_wr) begin
        sbim_r <= WDATA[3:2];
        if (WDATA[1:0] == `SWR_FIRST) begin
          swr_armed_r <= 1'b1;
        end else if (WDATA[1:0] == `SWR_SECOND) begin
          swr_go_r    <= swr_armed_r;
          swr_armed_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Control, status and word engine
  // ----------------------------------------
  // Hardware updates come after software ones so hardware always wins
  always @(posedge CLK) begin
    if (clr) begin
      bc_r         <= 3'h0;
      ack_r        <= 1'b0;
      sck_r        <= 3'h0;
      shreg_r      <= 8'h00;
      mst_r        <= 1'b0;
      trx_r        <= 1'b0;
      bb_r         <= 1'b0;
      pin_r        <= 1'b1;
      al_r         <= 1'b0;
      aas_r        <= 1'b0;
      gcall_seen_r <= 1'b0;
      lrb_r        <= 1'b0;
      sa_r         <= 7'h00;
      als_r        <= 1'b0;
      prescaler_enable_r       <= 1'b0;
      run_sel_r    <= 1'b0;
      first_r      <= 1'b0;
      session_r    <= 1'b0;
      bitcnt_r     <= 4'h0;
      stop_req_r   <= 1'b0;
      stretch_r    <= 1'b0;
      rcnt_r       <= `ZERO16;
      WORD_DONE_IRQ <= 1'b0;
      STOP_SEEN_IRQ <= 1'b0;
    end else begin
      WORD_DONE_IRQ <= 1'b0;
      STOP_SEEN_IRQ <= 1'b0;
      if (WR & (ADDR == `A_CTL1)) begin
        bc_r  <= WDATA[7:5];
        ack_r <= WDATA[4];
        sck_r <= WDATA[2:0];
      end
      if (WR & (ADDR == `A_OWN)) begin
        sa_r  <= WDATA[7:1];
        als_r <= WDATA[0];
      end
      if (WR & (ADDR == `A_RATE)) begin
        prescaler_enable_r <= WDATA[`PRESCALER_ENABLE_BIT];
      end
      if (WR & (ADDR == `A_IDLE)) begin
        run_sel_r <= WDATA[`RUN_BIT];
      end
      // Any buffer access re-arms the transfer
      if (dbr_acc) begin
        pin_r <= 1'b1;
        al_r  <= 1'b0;
        aas_r <= 1'b0;
      end
      if (WR & (ADDR == `A_BUF)) begin
        shreg_r <= WDATA;
      end
      if (c2_wr) begin
        al_r <= 1'b0;
        if (c2_start) begin
          mst_r <= 1'b1;
          trx_r <= 1'b1;
          pin_r <= 1'b1;
        end else if (c2_stop) begin
          stop_req_r <= 1'b1;
          pin_r      <= 1'b1;
        end else begin
          mst_r <= WDATA[7];
          trx_r <= WDATA[6];
          if (WDATA[4]) begin
            pin_r <= 1'b1;            // a zero written here never clears
          end
        end
      end
      // Slave clock release waits one low time after pending is set
      if (~pin_r) begin
        rcnt_r <= `ZERO16;
      end else if (stretch_r & run) begin
        if (rcnt_r >= half) begin
          stretch_r <= 1'b0;
          rcnt_r    <= `ZERO16;
        end else begin
          rcnt_r <= rcnt_r + `ONE16;
        end
      end
      // Bus events
      if (start_det) begin
        bb_r         <= 1'b1;
        first_r      <= 1'b1;
        session_r    <= 1'b0;
        bitcnt_r     <= 4'h0;
        gcall_seen_r <= 1'b0;
      end else if (stop_det) begin
        bb_r         <= 1'b0;
        STOP_SEEN_IRQ <= bb_r;
        mst_r        <= 1'b0;
        trx_r        <= 1'b0;
        first_r      <= 1'b0;
        session_r    <= 1'b0;
        bitcnt_r     <= 4'h0;
        gcall_seen_r <= 1'b0;
        stop_req_r   <= 1'b0;
        stretch_r    <= 1'b0;
      end else if (scl_rise & bb_r) begin
        lrb_r    <= sda_s_r;
        bitcnt_r <= bitcnt_r + 4'h1;
        if (in_data) begin
          shreg_r <= {shreg_r[6:0], sda_s_r};
        end
        // Released line read low: another master won
        if (mst_r & trx_r & in_data & ~BUS_DATA_LINE_OE & ~sda_s_r) begin
          al_r  <= 1'b1;
          mst_r <= 1'b0;
          trx_r <= 1'b0;
        end
      end else if (scl_fall & bb_r & (bitcnt_r == total)) begin
        bitcnt_r <= 4'h0;
        first_r  <= 1'b0;
        if (addr_word & mst_r) begin
          WORD_DONE_IRQ <= 1'b1;
          pin_r         <= 1'b0;
          if (~lrb_r) begin
            trx_r <= ~shreg_r[0];
          end
        end else if (hit) begin
          WORD_DONE_IRQ <= 1'b1;
          pin_r         <= 1'b0;
          stretch_r     <= 1'b1;
          aas_r         <= 1'b1;
          gcall_seen_r  <= gcall;
          trx_r         <= shreg_r[0];
          session_r     <= 1'b1;
        end else if (al_r) begin
          WORD_DONE_IRQ <= 1'b1;
        end else if (~addr_word & engaged) begin
          WORD_DONE_IRQ <= 1'b1;
          pin_r         <= 1'b0;
          stretch_r     <= ~mst_r;
          session_r     <= 1'b1;
          if (first_r) begin
            aas_r <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Master clock and start/stop sequencer
  // ----------------------------------------
  // High phase counts only once the line is seen high, so slow slaves stretch it
  always @(posedge CLK) begin
    if (clr | ~mode_on) begin
      state_r <= M_IDLE;
      hcnt_r  <= `ZERO16;
    end else begin
      case (state_r)
        M_IDLE: begin
          hcnt_r <= `ZERO16;
          if (c2_start) begin
            state_r <= M_START;
          end
        end
        M_START: begin
          if (run) begin
            if (hcnt_r >= half) begin
              state_r <= M_LOW;
              hcnt_r  <= `ZERO16;
            end else begin
              hcnt_r <= hcnt_r + `ONE16;
            end
          end
        end
        M_LOW: begin
          if (~pin_r) begin
            hcnt_r <= `ZERO16;
          end else if (run) begin
            if (hcnt_r >= half) begin
              hcnt_r <= `ZERO16;
              if (stop_req_r) begin
                state_r <= M_STOP;
              end else if (~mst_r & (bitcnt_r == 4'h0)) begin
                state_r <= M_IDLE;    // lost word is finished
              end else begin
                state_r <= M_HIGH;
              end
            end else begin
              hcnt_r <= hcnt_r + `ONE16;
            end
          end
        end
        M_HIGH: begin
          if (~scl_s_r) begin
            hcnt_r <= `ZERO16;
          end else if (run) begin
            if (hcnt_r >= half) begin
              state_r <= M_LOW;
              hcnt_r  <= `ZERO16;
            end else begin
              hcnt_r <= hcnt_r + `ONE16;
            end
          end
        end
        M_STOP: begin
          if (run) begin
            if (hcnt_r >= half) begin
              state_r <= M_REL;
              hcnt_r  <= `ZERO16;
            end else begin
              hcnt_r <= hcnt_r + `ONE16;
            end
          end
        end
        M_REL: begin
          if (~scl_s_r) begin
            hcnt_r <= `ZERO16;
          end else if (run) begin
            if (hcnt_r >= half) begin
              state_r <= M_END;
              hcnt_r  <= `ZERO16;
            end else begin
              hcnt_r <= hcnt_r + `ONE16;
            end
          end
        end
        M_END: begin
          if (~bb_r) begin
            state_r <= M_IDLE;
          end
        end
        default: begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end

  wire fsm_scl_low = (state_r == M_LOW) | (state_r == M_STOP);
  wire fsm_sda_low = (state_r == M_START) | (state_r == M_STOP) | (state_r == M_REL);
  wire fsm_sda_rel = state_r == M_END;

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Data may only move while the clock is seen low, else a false start/stop
  always @(posedge CLK) begin
    if (clr | ~mode_on) begin
      BUS_CLOCK_LINE_OE <= 1'b0;
      BUS_CLOCK_LINE_O  <= 1'b1;
      BUS_DATA_LINE_OE  <= 1'b0;
      BUS_DATA_LINE_O   <= 1'b1;
    end else begin
      BUS_CLOCK_LINE_OE <= fsm_scl_low | stretch_r;
      BUS_CLOCK_LINE_O  <= ~(fsm_scl_low | stretch_r);
      if (fsm_sda_low) begin
        BUS_DATA_LINE_OE <= 1'b1;
        BUS_DATA_LINE_O  <= 1'b0;
      end else if (fsm_sda_rel) begin
        BUS_DATA_LINE_OE <= 1'b0;
        BUS_DATA_LINE_O  <= 1'b1;
      end else if (~scl_s_r) begin
        BUS_DATA_LINE_OE <= want_low;
        BUS_DATA_LINE_O  <= ~want_low;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      if (ADDR == `A_CTL1) begin
        RDATA <= {bc_r, ack_r, 1'b0, sck_r};
      end else if (ADDR == `A_BUF) begin
        RDATA <= shreg_r;
      end else if (ADDR == `A_CTL2) begin
        RDATA <= {mst_r, trx_r, bb_r, pin_r, al_r, aas_r, gcall_seen_r, lrb_r};
      end else if (ADDR == `A_OWN) begin
        RDATA <= {sa_r, als_r};
      end else if (ADDR == `A_RATE) begin
        RDATA <= {1'b0, prescaler_enable_r, 6'h00};
      end else if (ADDR == `A_IDLE) begin
        RDATA <= {7'h00, run_sel_r};
      end else begin
        RDATA <= 8'h00;
      end
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule // two_wire_bus_transfer_engine

`default_nettype wire

//--- tb/twi_engine_properties.sv
// Port-level checker for the two-wire transfer engine.
// Assumes one system clock domain and the register map header.
`timescale 1ns/1ns
`include "twi_regs.vh"
`default_nettype none

module twi_engine_properties (
  input wire logic       CLK,               // System clock
  input wire logic       SYS_RST,           // Synchronous reset
  input wire logic [2:0] ADDR,              // Register address
  input wire logic [7:0] WDATA,             // Write data
  input wire logic       WR,                // Write strobe
  input wire logic       RD,                // Read strobe
  input wire logic       BUS_CLOCK_LINE_I,  // Clock line level
  input wire logic       BUS_CLOCK_LINE_OE, // Clock line pull
  input wire logic       BUS_DATA_LINE_I,   // Data line level
  input wire logic       BUS_DATA_LINE_OE,  // Data line pull
  input wire logic       WORD_DONE_IRQ,     // Word pulse
  input wire logic       STOP_SEEN_IRQ      // Stop pulse
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  // ----------------------------------------
  // Word and stop events
  // ----------------------------------------
  a_word_irq_single: assert property (WORD_DONE_IRQ |=> !WORD_DONE_IRQ)
    else $error("word pulse longer than one cycle");
  a_irq_clock_low: assert property (WORD_DONE_IRQ |-> !BUS_CLOCK_LINE_I)
    else $error("word pulse while clock line high");
  a_stop_lines_high: assert property (STOP_SEEN_IRQ |-> BUS_CLOCK_LINE_I && BUS_DATA_LINE_I)
    else $error("stop pulse without both lines high");
  a_stop_irq_single: assert property (STOP_SEEN_IRQ |=> !STOP_SEEN_IRQ [*8])
    else $error("stop pulse repeated too soon");

  // ----------------------------------------
  // Start and clock timing
  // ----------------------------------------
  // Lines high and own clock free stands in for the busy flag
  a_start_request: assert property ((WR && ADDR == `A_CTL2 && WDATA[7:4] == 4'hF
      && WDATA[3:2] == `SBIM_I2C && BUS_CLOCK_LINE_I && BUS_DATA_LINE_I
      && !BUS_CLOCK_LINE_OE) |-> ##[1:6] BUS_DATA_LINE_OE)
    else $error("start write gave no start");
  a_start_hold: assert property ($rose(BUS_DATA_LINE_OE) && BUS_CLOCK_LINE_I
      |=> !BUS_CLOCK_LINE_OE [*8])
    else $error("clock pulled too soon after start");
  a_clock_high_width: assert property ($fell(BUS_CLOCK_LINE_OE) |=> !BUS_CLOCK_LINE_OE [*8])
    else $error("clock high phase too short");
  a_clock_low_width: assert property ($rose(BUS_CLOCK_LINE_OE) |=> BUS_CLOCK_LINE_OE [*8])
    else $error("clock low phase too short");
  a_release_delay: assert property ((WR || RD) && ADDR == `A_BUF && BUS_CLOCK_LINE_OE
      |=> BUS_CLOCK_LINE_OE [*8])
    else $error("stretched clock released before low time");

  c_word: cover property (WORD_DONE_IRQ);
  c_stop: cover property (STOP_SEEN_IRQ);
  c_start: cover property ($rose(BUS_DATA_LINE_OE) && BUS_CLOCK_LINE_I);
endmodule // twi_engine_properties

bind two_wire_bus_transfer_engine twi_engine_properties twi_engine_properties_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .BUS_CLOCK_LINE_I(BUS_CLOCK_LINE_I), .BUS_CLOCK_LINE_OE(BUS_CLOCK_LINE_OE),
  .BUS_DATA_LINE_I(BUS_DATA_LINE_I), .BUS_DATA_LINE_OE(BUS_DATA_LINE_OE),
  .WORD_DONE_IRQ(WORD_DONE_IRQ), .STOP_SEEN_IRQ(STOP_SEEN_IRQ));
`default_nettype wire

//--- tb/twi_bus_slave_model.sv
// Behavioural slave on the two-wire bus: acks its address, takes or sends bytes.
// Assumes resolved line levels with pull-ups; it only ever pulls data low.
`timescale 1ns/1ns
`default_nettype none

module twi_bus_slave_model #(
  parameter logic [6:0] ADR = 7'h50, // Address answered
  parameter logic [7:0] TXB = 8'h3C  // Byte sent on reads
) (
  input  wire logic       scl,       // Resolved clock line
  input  wire logic       sda,       // Resolved data line
  output var  logic       sda_pull,  // High pulls data low
  output var  logic [7:0] last_byte, // Last byte on the bus
  output var  logic       got_nack   // Read ended by high bit
);
  logic [7:0] shreg;
  int         bit_i;
  logic       in_frame;
  logic       is_addr;
  logic       rd;
  logic       sel;

  initial begin
    sda_pull = 1'b0;
    in_frame = 1'b0;
  end

  // Start: data falls while clock high
  always @(negedge sda) if (scl) begin
    in_frame = 1'b1;
    bit_i = 0;
    is_addr = 1'b1;
    sel = 1'b0;
    rd = 1'b0;
    got_nack = 1'b0;
  end

  // Stop: data rises while clock high
  always @(posedge sda) if (scl) begin
    in_frame = 1'b0;
    sda_pull = 1'b0;
  end

  // Sample on rising clock, MSB first; a high ninth bit ends a read
  always @(posedge scl) if (in_frame) begin
    if (bit_i < 8) shreg = {shreg[6:0], sda};
    else if (rd && !is_addr && sda) begin
      got_nack = 1'b1;
      sel = 1'b0;
    end
    bit_i++;
  end

  // Change data only while clock low, so no false start or stop
  always @(negedge scl) if (in_frame) begin
    if (bit_i == 8) begin
      last_byte = shreg;
      if (is_addr) begin
        sel = (shreg[7:1] == ADR);
        rd = shreg[0];
      end
      sda_pull = sel && !(rd && !is_addr);
    end else if (bit_i == 9) begin
      bit_i = 0;
      is_addr = 1'b0;
      sda_pull = sel && rd && !TXB[7];
    end else begin
      sda_pull = sel && rd && !is_addr && !TXB[7 - bit_i];
    end
  end
endmodule // twi_bus_slave_model
`default_nettype wire

//--- tb/two_wire_bus_transfer_engine_tb.sv
// Self-checking bench: register port tasks plus a slave model on the lines.
// Assumes the engine as master; lines resolve as pull-up wired-AND.
`timescale 1ns/1ns
`include "twi_regs.vh"
`default_nettype none

module two_wire_bus_transfer_engine_tb;
  logic       CLK, SYS_RST, WR, RD, DEEP_IDLE_STATE;
  logic [2:0] ADDR;
  logic [7:0] WDATA, RDATA, last_byte;
  logic       cl_o, cl_oe, dl_o, dl_oe, WORD_DONE_IRQ, STOP_SEEN_IRQ;
  logic       sda_pull, got_nack;
  wire        scl = !cl_oe;
  wire        sda = !dl_oe && !sda_pull;
  int         errors, check_count, cyc;

  two_wire_bus_transfer_engine two_wire_bus_transfer_engine_inst (
    .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .DEEP_IDLE_STATE(DEEP_IDLE_STATE),
    .BUS_CLOCK_LINE_I(scl), .BUS_CLOCK_LINE_O(cl_o), .BUS_CLOCK_LINE_OE(cl_oe),
    .BUS_DATA_LINE_I(sda), .BUS_DATA_LINE_O(dl_o), .BUS_DATA_LINE_OE(dl_oe),
    .WORD_DONE_IRQ(WORD_DONE_IRQ), .STOP_SEEN_IRQ(STOP_SEEN_IRQ));

  twi_bus_slave_model twi_bus_slave_model_inst (
    .scl(scl), .sda(sda), .sda_pull(sda_pull), .last_byte(last_byte), .got_nack(got_nack));

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // Whole run needs about 3100 cycles; ceiling leaves wide margin
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Register port and compare tasks
  // ----------------------------------------
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Mask of zero reads without comparing
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m,
                    input string name);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    if (m != 8'h00) check8(name, exp, RDATA & m);
  endtask

  // Pulses last one cycle, so look once per cycle between edges
  task automatic wait_irq(input bit stop_kind);
    int n;
    n = 0;
    while (n < 3000 && ((stop_kind ? STOP_SEEN_IRQ : WORD_DONE_IRQ) !== 1'b1)) begin
      @(negedge CLK);
      n++;
    end
    check8(stop_kind ? "stop_irq" : "word_irq", 8'h01, {7'h00, n < 3000});
    check8("line_drive", {6'h00, ~cl_oe, ~dl_oe}, {6'h00, cl_o, dl_o});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    SYS_RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 3'h0;
    WDATA = 8'h00;
    DEEP_IDLE_STATE = 1'b0;
    errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(`A_CTL2, 8'h10, 8'hFF, "status_reset");
    rd(3'h6, 8'h00, 8'hFF, "unmapped");
    wr(`A_RATE, 8'h40);
    rd(`A_RATE, 8'h40, 8'hFF, "rate_config_one");
    wr(`A_IDLE, 8'h01);
    rd(`A_IDLE, 8'h01, 8'hFF, "idle_behavior_reg");
    wr(`A_OWN, 8'hA4);
    rd(`A_OWN, 8'hA4, 8'hFF, "own_address_reg");
    wr(`A_CTL1, 8'h10);
    wr(`A_CTL2, 8'h18);
    // Nobody answers: direction kept, last bit high, then stop
    wr(`A_BUF, 8'h66);
    wr(`A_CTL2, 8'hF8);
    wait_irq(0);
    rd(`A_CTL2, 8'hE1, 8'hFF, "status_no_ack");
    wr(`A_CTL2, 8'hD8);
    wait_irq(1);
    rd(`A_CTL2, 8'h10, 8'hFE, "status_stopped");
    // Write address and one word, second word under deep idle
    wr(`A_BUF, 8'hA0);
    wr(`A_CTL2, 8'hF8);
    wait_irq(0);
    check8("address_byte", 8'hA0, last_byte);
    rd(`A_CTL2, 8'hE0, 8'hFF, "status_write");
    // Deep idle without run select freezes the word, run select resumes it
    wr(`A_IDLE, 8'h00);
    DEEP_IDLE_STATE <= 1'b1;
    wr(`A_BUF, 8'h5A);
    repeat (800) @(posedge CLK);
    rd(`A_CTL2, 8'hF0, 8'hFF, "status_frozen");
    wr(`A_IDLE, 8'h01);
    wait_irq(0);
    check8("data_byte", 8'h5A, last_byte);
    rd(`A_CTL2, 8'hE0, 8'hFF, "status_data_ack");
    @(posedge CLK);
    DEEP_IDLE_STATE <= 1'b0;
    wr(`A_CTL2, 8'hD8);
    wait_irq(1);
    // Read address, last word without ack, then one-bit not-acknowledge
    wr(`A_BUF, 8'hA1);
    wr(`A_CTL2, 8'hF8);
    wait_irq(0);
    rd(`A_CTL2, 8'hA0, 8'hFF, "status_read");
    rd(`A_BUF, 8'h00, 8'h00, "");
    wait_irq(0);
    // Own acknowledge low shows up as last bit zero
    rd(`A_CTL2, 8'hA0, 8'hFF, "status_acked");
    wr(`A_CTL1, 8'h00);
    rd(`A_BUF, 8'h3C, 8'hFF, "first_word");
    wait_irq(0);
    wr(`A_CTL1, 8'h20);
    rd(`A_BUF, 8'h3C, 8'hFF, "read_word");
    wait_irq(0);
    check8("not_ack_bit", 8'h01, {7'h00, got_nack});
    wr(`A_CTL2, 8'hD8);
    wait_irq(1);
    wrap_up;
  end
endmodule // two_wire_bus_transfer_engine_tb
`default_nettype wire
